// ==== hdl/rbc_top.sv ====
// Purpose: receive buffer count and status register of an ethernet controller
// Assumes: AHB-Lite slave, single word transfers, one clock
// Notes: zero wait state slave, always OKAY
// Notes on behaviour
// - each received packet raises the count by its descriptor count, up to 0xFF, except in a cycle with a decrement
// - increment at 0xFF leaves the count at 0xFF
// - decrement at zero leaves the count at zero
// - simultaneous increment and decrement leave the count unchanged
// - with flow control on, reception halts while the count is 0xFF
// - with flow control off, reception continues while saturated
// - nonzero count sets packet pending, interrupt if its enable set
// - writing the descriptor start address clears the count
// - switching the module off keeps the count
// - status bit 7 shows module on or still finishing work
// - status bit 6 is transmit busy, cleared when off
// - status bit 5 is receive busy, cleared when off
// - status bits 31-24, 15-8 and 4-0 read zero
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module rbc_top
	import rbc_pkg::*;
(
	// ahb-lite slave
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// receive dma
	input  wire logic        rx_packet_done,
	input  wire logic [7:0]  rx_desc_used,
	output logic             rx_halt,
	// activity
	input  wire logic        tx_active,
	input  wire logic        rx_active,
	// status
	output logic             packet_pending_flag,
	output logic             irq
);
	typedef struct packed {
		logic       wr_pend;
		logic [7:0] wr_addr;
		logic       on;
		logic       flow;
		logic       irq_st;
		logic       irq_en;
		logic [31:0] rxst;
		logic [31:0] rdata;
	} rbc_top_state_t;

	rbc_top_state_t state_r;
	rbc_top_state_t state_nxt;
	logic [7:0]     rx_buffer_count;
	logic           mod_busy;
	logic           tx_busy;
	logic           rx_busy;
	logic           addr_ok;
	logic           wr_ctl;
	logic           dec;
	logic           clr;
	logic           inc;
	logic [31:0]    status_word;

	assign addr_ok = hsel && hready && htrans == RBC_HTRANS_NSEQ;
	assign wr_ctl  = state_r.wr_pend && state_r.wr_addr == RBC_OFF_CONTROL;
	assign dec     = wr_ctl && hwdata[RBC_CTL_DEC];
	assign clr     = state_r.wr_pend && state_r.wr_addr == RBC_OFF_RXST;
	assign rx_halt = state_r.flow && rx_buffer_count == RBC_CNT_MAX;
	assign inc     = rx_packet_done && !rx_halt;
	assign packet_pending_flag = rx_buffer_count != RBC_CNT_ZERO;

	always_comb
	begin
		status_word = RBC_WORD_ZERO;
		status_word[RBC_CNT_MSB:RBC_CNT_LSB] = rx_buffer_count;
		status_word[RBC_MOD_BUSY] = mod_busy;
		status_word[RBC_TX_BUSY]  = tx_busy;
		status_word[RBC_RX_BUSY]  = rx_busy;
	end

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.wr_pend = addr_ok && hwrite && hsize == RBC_HSIZE_WORD;
		state_nxt.wr_addr = haddr[7:0];
		if (wr_ctl)
		begin
			state_nxt.on   = hwdata[RBC_CTL_ON];
			state_nxt.flow = hwdata[RBC_CTL_FLOW];
		end
		if (clr)
			state_nxt.rxst = hwdata;
		if (state_r.wr_pend && state_r.wr_addr == RBC_OFF_IRQ_EN)
			state_nxt.irq_en = hwdata[RBC_IRQ_PEND];
		if (state_r.wr_pend && state_r.wr_addr == RBC_OFF_IRQ_ST
			&& hwdata[RBC_IRQ_PEND])
			state_nxt.irq_st = 1'b0;
		if (packet_pending_flag)
			state_nxt.irq_st = 1'b1;
		state_nxt.rdata = RBC_WORD_ZERO;
		if (addr_ok && !hwrite)
		begin
			unique case (haddr[7:0])
				RBC_OFF_STATUS:  state_nxt.rdata = status_word;
				RBC_OFF_CONTROL: state_nxt.rdata = {16'h0000,
					state_r.on, 13'h0000, state_r.flow, 1'b0};
				RBC_OFF_RXST:    state_nxt.rdata = state_r.rxst;
				RBC_OFF_IRQ_ST:  state_nxt.rdata = {31'h0000_0000,
					state_r.irq_st};
				RBC_OFF_IRQ_EN:  state_nxt.rdata = {31'h0000_0000,
					state_r.irq_en};
				default:         state_nxt.rdata = RBC_WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign hrdata    = state_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign irq       = state_r.irq_st & state_r.irq_en;

	rbc_counter u_counter (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.inc_valid  (inc),
		.inc_amount (rx_desc_used),
		.dec        (dec),
		.clear      (clr),
		.count      (rx_buffer_count)
	);

	rbc_busy u_busy (
		.hclk               (hclk),
		.hresetn            (hresetn),
		.module_on          (state_r.on),
		.tx_active          (tx_active),
		.rx_active          (rx_active),
		.module_busy_flag   (mod_busy),
		.transmit_busy_flag (tx_busy),
		.receive_busy_flag  (rx_busy)
	);
endmodule : rbc_top

// ==== hdl/rbc_pkg.sv ====
// Purpose: shared constants of the receive buffer count status block
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: offsets are byte addresses
package rbc_pkg;
	localparam logic [7:0]  RBC_OFF_STATUS  = 8'h00;
	localparam logic [7:0]  RBC_OFF_CONTROL = 8'h04;
	localparam logic [7:0]  RBC_OFF_RXST    = 8'h08;
	localparam logic [7:0]  RBC_OFF_IRQ_ST  = 8'h0C;
	localparam logic [7:0]  RBC_OFF_IRQ_EN  = 8'h10;
	localparam int          RBC_CNT_LSB     = 16;
	localparam int          RBC_CNT_MSB     = 23;
	localparam int          RBC_MOD_BUSY    = 7;
	localparam int          RBC_TX_BUSY     = 6;
	localparam int          RBC_RX_BUSY     = 5;
	localparam int          RBC_CTL_DEC     = 0;
	localparam int          RBC_CTL_FLOW    = 1;
	localparam int          RBC_CTL_ON      = 15;
	localparam int          RBC_IRQ_PEND    = 0;
	localparam logic [7:0]  RBC_CNT_MAX     = 8'hFF;
	localparam logic [7:0]  RBC_CNT_ZERO    = 8'h00;
	localparam logic [1:0]  RBC_HTRANS_NSEQ = 2'b10;
	localparam logic [2:0]  RBC_HSIZE_WORD  = 3'b010;
	localparam logic [31:0] RBC_WORD_ZERO   = 32'h0000_0000;
endpackage : rbc_pkg

// ==== hdl/rbc_counter.sv ====
// Purpose: saturating receive buffer count
// Assumes: increment amount comes from the receive dma on hclk
// Notes: clear has priority over count updates
`timescale 1ns/1ns
module rbc_counter
	import rbc_pkg::*;
(
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// updates
	input  wire logic       inc_valid,
	input  wire logic [7:0] inc_amount,
	input  wire logic       dec,
	input  wire logic       clear,
	// state
	output logic      [7:0] count
);
	typedef struct packed {
		logic [7:0] count;
	} rbc_cnt_state_t;

	rbc_cnt_state_t state_r;
	rbc_cnt_state_t state_nxt;
	logic [8:0]     sum;

	always_comb
	begin
		state_nxt = state_r;
		sum = {1'b0, state_r.count} + {1'b0, inc_amount};
		if (clear)
			state_nxt.count = RBC_CNT_ZERO;
		else if (inc_valid && dec)
			state_nxt.count = state_r.count;
		else if (inc_valid)
			state_nxt.count = sum[8] ? RBC_CNT_MAX : sum[7:0];
		else if (dec && state_r.count != RBC_CNT_ZERO)
			state_nxt.count = state_r.count - 8'h01;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign count = state_r.count;
endmodule : rbc_counter

// ==== hdl/rbc_busy.sv ====
// Purpose: module, transmit and receive busy flags
// Assumes: activity inputs are on hclk
// Notes: transmit and receive flags drop when the module is off, module flag once activity ends
`timescale 1ns/1ns
module rbc_busy
	import rbc_pkg::*;
(
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// activity
	input  wire logic module_on,
	input  wire logic tx_active,
	input  wire logic rx_active,
	// flags
	output logic      module_busy_flag,
	output logic      transmit_busy_flag,
	output logic      receive_busy_flag
);
	typedef struct packed {
		logic mod;
		logic tx;
		logic rx;
	} rbc_busy_state_t;

	rbc_busy_state_t state_r;
	rbc_busy_state_t state_nxt;

	always_comb
	begin
		state_nxt.tx  = module_on & tx_active;
		state_nxt.rx  = module_on & rx_active;
		state_nxt.mod = module_on | tx_active | rx_active;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign module_busy_flag   = state_r.mod;
	assign transmit_busy_flag = state_r.tx;
	assign receive_busy_flag  = state_r.rx;
endmodule : rbc_busy

// ==== test/rbc_props.sv ====
// Purpose: port checks of rbc_top
// Assumes: zero wait state slave
// Notes: count is seen through flags and reads
`timescale 1ns/1ns
module rbc_props
	import rbc_pkg::*;
(
	// bus
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	// dma and status
	input wire logic        rx_packet_done,
	input wire logic [7:0]  rx_desc_used,
	input wire logic        rx_halt,
	input wire logic        packet_pending_flag,
	input wire logic        irq
);
	logic tk;
	logic rd_r;
	logic wr_r;
	assign tk = hsel && hready && htrans == RBC_HTRANS_NSEQ;
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			rd_r <= 1'b0;
			wr_r <= 1'b0;
		end
		else
		begin
			rd_r <= tk && !hwrite && haddr[7:0] == RBC_OFF_STATUS;
			wr_r <= tk && hwrite;
		end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_st;
		rd_r;
	endsequence
	a_free_zero: assert property (s_st |-> hrdata[31:24] == 8'h00
		&& hrdata[15:8] == 8'h00 && hrdata[4:0] == 5'h00)
		else $error("status spare bits set");
	a_halt_pend: assert property (rx_halt |-> packet_pending_flag)
		else $error("halt with zero count");
	a_halt_hold: assert property (rx_halt && !wr_r |=> rx_halt)
		else $error("halt dropped");
	a_halt_rise: assert property ($rose(rx_halt) |->
		$past(rx_packet_done) || $past(wr_r)) else $error("halt no cause");
	a_pend_rise: assert property ($rose(packet_pending_flag) |->
		$past(rx_packet_done) && $past(rx_desc_used) != 8'h00)
		else $error("pending without packet");
	a_pend_fall: assert property ($fell(packet_pending_flag) |->
		$past(wr_r)) else $error("pending lost");
	a_irq_rise: assert property ($rose(irq) |->
		$past(packet_pending_flag) || $past(wr_r)) else $error("irq no cause");
	a_reset_idle: assert property ($rose(hresetn) |->
		!packet_pending_flag && !irq && !rx_halt) else $error("not idle");
endmodule : rbc_props
bind rbc_top rbc_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .rx_packet_done(rx_packet_done),
	.rx_desc_used(rx_desc_used), .rx_halt(rx_halt),
	.packet_pending_flag(packet_pending_flag), .irq(irq));

// ==== test/rbc_dma_model.sv ====
// Purpose: receive dma stand-in
// Assumes: one packet per request
// Notes: waits out halt before reporting
`timescale 1ns/1ns
module rbc_dma_model
(
	// requests
	input wire logic       hclk,
	input wire logic       rx_halt,
	input wire logic       req,
	input wire logic [7:0] amount,
	// packet report
	output logic           rx_packet_done = 1'b0,
	output logic [7:0]     rx_desc_used = 8'h00
);
	logic pend_r = 1'b0;
	always @(posedge hclk)
	begin
		rx_packet_done <= 1'b0;
		rx_desc_used <= ~rx_desc_used;
		pend_r <= pend_r || req;
		if ((req || pend_r) && !rx_halt)
		begin
			rx_packet_done <= 1'b1;
			rx_desc_used <= amount;
			pend_r <= 1'b0;
		end
	end
endmodule : rbc_dma_model

// ==== test/tb_top.sv ====
// Purpose: bench of rbc_top
// Assumes: zero wait state slave
// Notes: count is read in status bits 23-16
`timescale 1ns/1ns
module tb_top
	import rbc_pkg::*;
;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  hsize = RBC_HSIZE_WORD;
	logic        hrdy, hresp, done, halt, pend, irq;
	logic        tx_a = 1'b0, rx_a = 1'b0, req = 1'b0;
	logic [7:0]  used, amt = 8'h01;
	logic [31:0] rd_q;
	int          n_fail, samples_checked, cyc;
	rbc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
		.rx_packet_done(done), .rx_desc_used(used), .rx_halt(halt),
		.tx_active(tx_a), .rx_active(rx_a), .packet_pending_flag(pend),
		.irq(irq));
	rbc_dma_model dma (.hclk(hclk), .rx_halt(halt), .req(req), .amount(amt),
		.rx_packet_done(done), .rx_desc_used(used));
	initial
		forever #20 hclk = ~hclk;
	task complete_run;
		$display("fails %0d checks %0d", n_fail, samples_checked);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		repeat (2) @(posedge hclk);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= RBC_HTRANS_NSEQ;
		@(posedge hclk);
		while (hrdy !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hrdy !== 1'b1)
			@(posedge hclk);
		@(negedge hclk);
		rd = rd_q;
	endtask : xfer
	task st(input logic [7:0] c, input logic [2:0] b);
		xfer(RBC_OFF_STATUS, 1'b0, 32'h0000_0000);
		chk("status", {8'h00, c, 8'h00, b, 5'h00}, rd);
	endtask : st
	task pkt(input logic [7:0] a);
		amt <= a;
		req <= 1'b1;
		@(posedge hclk);
		req <= 1'b0;
		@(posedge hclk);
	endtask : pkt
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		st(8'h00, 3'b000);
		xfer(8'h20, 1'b0, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rd);
		xfer(RBC_OFF_IRQ_EN, 1'b1, 32'h0000_0001);
		pkt(8'h03);
		st(8'h03, 3'b000);
		chk("pend irq", 32'h0000_0003, {30'h0, pend, irq});
		xfer(RBC_OFF_IRQ_EN, 1'b1, 32'h0000_0000);
		chk("masked", 32'h0000_0000, {31'h0, irq});
		xfer(RBC_OFF_IRQ_EN, 1'b1, 32'h0000_0001);
		tx_a <= 1'b1;
		rx_a <= 1'b1;
		xfer(RBC_OFF_CONTROL, 1'b1, 32'h0000_8001);
		st(8'h02, 3'b111);
		xfer(RBC_OFF_CONTROL, 1'b1, 32'h0000_0000);
		st(8'h02, 3'b100);
		tx_a <= 1'b0;
		rx_a <= 1'b0;
		st(8'h02, 3'b000);
		fork
			xfer(RBC_OFF_CONTROL, 1'b1, 32'h0000_0001);
			begin
				@(posedge hclk);
				pkt(8'h05);
			end
		join
		st(8'h02, 3'b000);
		pkt(8'hFF);
		st(8'hFF, 3'b000);
		pkt(8'h01);
		st(8'hFF, 3'b000);
		xfer(RBC_OFF_CONTROL, 1'b1, 32'h0000_0002);
		chk("halt", 32'h0000_0001, {31'h0, halt});
		pkt(8'h01);
		xfer(RBC_OFF_CONTROL, 1'b1, 32'h0000_0003);
		repeat (2) @(posedge hclk);
		st(8'hFF, 3'b000);
		xfer(RBC_OFF_RXST, 1'b1, 32'h1234_5678);
		st(8'h00, 3'b000);
		xfer(RBC_OFF_CONTROL, 1'b1, 32'h0000_0001);
		st(8'h00, 3'b000);
		chk("sticky", 32'h0000_0001, {30'h0, pend, irq});
		xfer(RBC_OFF_IRQ_ST, 1'b1, 32'h0000_0001);
		chk("cleared", 32'h0000_0000, {31'h0, irq});
		complete_run();
	end
	always @(posedge hclk)
		rd_q <= hrdata;
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_fail++;
			complete_run();
		end
	end
endmodule : tb_top
